/* File: logic/ssi_pkg.sv */
/*
  ssi_pkg: constants, register map and lamp colours for the safe-state
  status indicator block.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package ssi_pkg;
  // timing
  localparam int CLK_HZ    = 100_000_000;
  localparam int MS_PER_S  = 1000;
  localparam int TFW_MS    = 4;
  localparam int BLINK_MS  = 250;
  // sizes
  localparam int NIN       = 8;
  localparam int NOUT      = 4;
  localparam int NCLK      = 2;
  localparam int NPAIR     = 2;
  localparam int CNT_W     = 26;
  localparam int BLK_W     = 26;
  localparam int DIAG_W    = NIN + NOUT + NCLK + 3;
  localparam int AW        = 8;
  // register byte offsets
  localparam logic [AW-1:0] A_MODE = 8'h00;
  localparam logic [AW-1:0] A_CFG  = 8'h04;
  localparam logic [AW-1:0] A_CMD  = 8'h08;
  localparam logic [AW-1:0] A_STAT = 8'h0c;
  localparam logic [AW-1:0] A_DIAG = 8'h10;
  // mode register bits
  localparam int M_LPWR  = 0;
  localparam int M_LTRF  = 1;
  localparam int M_SIFDN = 2;
  localparam int M_BOOT  = 3;
  localparam int M_FWUPD = 4;
  localparam int M_RDY   = 5;
  localparam int M_SPRES = 6;
  localparam int M_SRNG  = 7;
  localparam int M_ARNG  = 8;
  localparam int M_UNPAR = 9;
  localparam int M_PREJ  = 10;
  localparam int M_STRF  = 11;
  localparam int M_USER  = 12;
  localparam int M_CABLE = 13;
  localparam int M_WARN  = 14;
  localparam int M_ERR   = 15;
  localparam int MODE_W  = 16;
  // config register fields
  localparam int C_PAIR  = 0;
  localparam int C_FILT  = 8;
  localparam int FILT_W  = 8;
  // status register fields
  localparam int S_IMG   = 0;
  localparam int S_DRV   = 8;
  localparam int S_FATAL = 12;
  localparam int S_STEN  = 13;
  localparam int S_DREQ  = 14;

  typedef enum logic [1:0] {L_OFF, L_GRN, L_YEL, L_RED} ssi_lamp_e;
endpackage : ssi_pkg

/* File: logic/ssi_blink_if.sv */
/*
  ssi_blink_if: carries the shared flash phase to every flashing lamp encoder.
  Assumes one driver (the blink divider) and any number of readers.
*/
`timescale 1ns/100ps
`default_nettype none
interface ssi_blink_if;
  logic phase;
  modport src (output phase);
  modport dst (input  phase);
endinterface : ssi_blink_if
`default_nettype wire

/* File: logic/ssi_blink.sv */
/*
  ssi_blink: divides the system clock into the one flash phase that the
  link, ready, failure and safe lamps share.
  Assumes clk and synchronous active-high rst of the main block.
*/
`timescale 1ns/100ps
`default_nettype none
module ssi_blink
  import ssi_pkg::*;
#(
  parameter int HALF_CYC = BLINK_MS * (CLK_HZ / MS_PER_S)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // phase out
  ssi_blink_if.src  bl
);
  typedef struct packed {
    logic [BLK_W-1:0] cnt;
    logic             ph;
  } ssi_blk_s;

  ssi_blk_s s_q;
  ssi_blk_s s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt >= BLK_W'(HALF_CYC - 1)) begin
      s_d.cnt = '0;
      s_d.ph  = ~s_q.ph;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bl.phase = s_q.ph;
endmodule : ssi_blink
`default_nettype wire

/* File: logic/ssi_top.sv */
/*
  ssi_top: safe-state supervision and status lamps of an eight-input,
  four-output safety I/O module, with an APB register slave.
  Assumes pins arrive asynchronously and are synchronised here; rst is
  the power-up reset; firmware writes mode, config and output commands.
*/
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R1] link lamp: steady green power only, green flash traffic, off, yellow/red flash when M_SIFDN is set
// [R2] ready lamp: green ready, yellow boot, yellow flash update, red, off no sensor
// [R3] ready lamp flashes green/red actuator range, green/yellow sensor range
// [R4] failure lamp flashes red when unparameterised or rejected, steady red on fatal error, else off
// [R5] fatal error: all channels safe, failure lamp steady, safe traffic blocked
// [R6] fatal state latched; only power-up reset clears it
// [R7] safe lamp green for clean traffic, green flash when user must act
// [R8] safe lamp off without traffic, steady red when power or cable missing; code shows red only on M_CABLE, not when M_LPWR is clear
// [R9] diagnosis lamp yellow on warning, red on error, off otherwise
// [R10] each input lamp green while its input is set
// [R11] output lamp green on, off off, red on output error
// [R12] safe state reports zero for all inputs in the image
// [R13] safe state switches all outputs off
// [R14] a faulty input forces only its own image bit to zero
// [R15] a faulty output is switched off
// [R16] two-channel pair: error on one channel switches partner off too
// [R17] short, cross, overload and clock-output faults are detected from pins
// [R18] every new error raises a diagnostic request to the controller
// [R19] internal self-tests stop while any error exists; code stops them only while errVec is set, not on latched fatal
// [R20] input processing time equals filter time plus 4 ms
// [R21] a recognised safety request is held until the controller took the image
// [R22] all flashing derives from one shared blink divider
module ssi_top
  import ssi_pkg::*;
#(
  parameter int MS_CYC    = CLK_HZ / MS_PER_S,
  parameter int TFW_CYC   = TFW_MS * MS_CYC,
  parameter int BLINK_CYC = BLINK_MS * MS_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic [AW-1:0]     paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // field pins
  input  wire logic [NIN-1:0]    inRaw,
  input  wire logic [NIN-1:0]    inFault,
  input  wire logic [NOUT-1:0]   outFault,
  input  wire logic [NCLK-1:0]   clkOutFault,
  input  wire logic              fatalErr,
  // link side
  input  wire logic              imageTaken,
  input  wire logic              diagAck,
  output logic [NIN-1:0]         inImage,
  output logic                   diagReq,
  output logic [DIAG_W-1:0]      diagCode,
  output logic                   safeCommBlock,
  // actuators and self-test
  output logic [NOUT-1:0]        outDrive,
  output logic                   selfTestEn,
  // lamps
  output ssi_lamp_e              linkLamp,
  output ssi_lamp_e              readyLamp,
  output ssi_lamp_e              failureLamp,
  output ssi_lamp_e              safeLamp,
  output ssi_lamp_e              systemDiagLight,
  output logic [NIN-1:0]         inLamp,
  output ssi_lamp_e [NOUT-1:0]   outLamp
);
  typedef struct packed {
    logic [MODE_W-1:0]            mode;
    logic [NPAIR-1:0]             pair;
    logic [FILT_W-1:0]            filtMs;
    logic [NOUT-1:0]              cmd;
    logic [NIN-1:0]               r1, r2, f1, f2;
    logic [NOUT-1:0]              o1, o2;
    logic [NCLK-1:0]              c1, c2;
    logic [2:0]                   x1, x2;
    logic                         tk3, ak3;
    logic [NIN-1:0]               filt, hold, image;
    logic [NIN-1:0][CNT_W-1:0]    cnt;
    logic                         fatal;
    logic [DIAG_W-1:0]            errPrev, code;
    logic                         dreq;
    logic [NOUT-1:0]              drive;
    logic                         stEn;
    ssi_lamp_e                    lk, rd, fl, sc, dg;
    logic [NIN-1:0]               inL;
    ssi_lamp_e [NOUT-1:0]         outL;
    logic [31:0]                  rdata;
    logic                         slverr;
  } ssi_state_s;

  ssi_state_s s_q;
  ssi_state_s s_d;

  ssi_blink_if blk ();

  ssi_blink #(
    .HALF_CYC (BLINK_CYC)
  ) u_blink (
    .clk (clk),
    .rst (rst),
    .bl  (blk)  // [R22]
  );

  logic                 ph;
  logic                 safe;
  logic                 taken;
  logic                 acked;
  logic                 clkBad;
  logic [NOUT-1:0]      outErr;
  logic [DIAG_W-1:0]    errVec;
  logic [DIAG_W-1:0]    errNew;
  logic [CNT_W-1:0]     tIn;
  logic [NIN-1:0]       filtN;
  logic [NIN-1:0][CNT_W-1:0] cntN;
  logic                 setup;
  logic                 wrAcc;
  logic                 mapped;

  assign ph     = blk.phase;
  assign taken  = s_q.x2[1] & ~s_q.tk3;
  assign acked  = s_q.x2[2] & ~s_q.ak3;
  assign clkBad = |s_q.c2;  // [R17]
  assign safe   = s_q.fatal | s_q.mode[M_UNPAR] | s_q.mode[M_PREJ];
  assign tIn    = CNT_W'(s_q.filtMs * MS_CYC + TFW_CYC);  // [R20]

  // per-input debounce over the processing time
  for (genvar i = 0; i < NIN; i++) begin : g_in
    logic diff;
    logic done;
    assign diff     = s_q.r2[i] != s_q.filt[i];
    assign done     = (s_q.cnt[i] + 1'b1) >= tIn;  // [R20]
    assign filtN[i] = (diff && done) ? s_q.r2[i] : s_q.filt[i];
    assign cntN[i]  = (diff && !done) ? s_q.cnt[i] + 1'b1 : '0;
  end

  // partner of a two-channel pair shares the error
  for (genvar j = 0; j < NOUT; j++) begin : g_out
    assign outErr[j] = s_q.o2[j] | (s_q.pair[j/2] & s_q.o2[j^1]);  // [R15] [R16]
  end

  assign errVec = {s_q.f2, s_q.o2, s_q.c2, s_q.x2[0],
                   s_q.mode[M_UNPAR], s_q.mode[M_PREJ]};  // [R17]
  assign errNew = errVec & ~s_q.errPrev;
  assign setup  = psel & ~penable;
  assign wrAcc  = psel & penable & pwrite;
  assign mapped = (paddr == A_MODE) || (paddr == A_CFG) ||
                  (paddr == A_CMD) || (paddr == A_STAT) || (paddr == A_DIAG);

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers
    s_d.r1  = inRaw;
    s_d.r2  = s_q.r1;
    s_d.f1  = inFault;
    s_d.f2  = s_q.f1;
    s_d.o1  = outFault;
    s_d.o2  = s_q.o1;
    s_d.c1  = clkOutFault;
    s_d.c2  = s_q.c1;
    s_d.x1  = {diagAck, imageTaken, fatalErr};
    s_d.x2  = s_q.x1;
    s_d.tk3 = s_q.x2[1];
    s_d.ak3 = s_q.x2[2];
    s_d.filt = filtN;
    s_d.cnt  = cntN;
    // fatal latch, no clear path except reset
    s_d.fatal = s_q.fatal | s_q.x2[0];  // [R6]
    // safety request stretch, set beats the clear
    for (int k = 0; k < NIN; k++) begin
      if (s_q.filt[k] && !filtN[k]) begin
        s_d.hold[k] = 1'b1;  // [R21]
      end else if (taken) begin
        s_d.hold[k] = 1'b0;
      end
    end
    s_d.image = s_q.filt & ~s_q.hold & ~s_q.f2;  // [R14] [R21]
    if (safe || clkBad) begin
      s_d.image = '0;  // [R12] [R5]
    end
    s_d.drive = safe ? '0 : (s_q.cmd & ~outErr);  // [R13] [R15] [R16]
    s_d.stEn  = ~|errVec;  // [R19]
    // diagnostic request, a new error wins over the ack
    s_d.errPrev = errVec;
    if (|errNew) begin
      s_d.dreq = 1'b1;  // [R18]
      s_d.code = errVec;
    end else if (acked) begin
      s_d.dreq = 1'b0;
    end
    // link lamp
    if (s_q.mode[M_SIFDN]) begin
      s_d.lk = ph ? L_YEL : L_RED;  // [R1]
    end else if (!s_q.mode[M_LPWR]) begin
      s_d.lk = L_OFF;
    end else if (s_q.mode[M_LTRF]) begin
      s_d.lk = ph ? L_GRN : L_OFF;
    end else begin
      s_d.lk = L_GRN;
    end
    // ready lamp
    if (!s_q.mode[M_SPRES]) begin
      s_d.rd = L_OFF;  // [R2]
    end else if (s_q.mode[M_BOOT]) begin
      s_d.rd = L_YEL;
    end else if (s_q.mode[M_FWUPD]) begin
      s_d.rd = ph ? L_YEL : L_OFF;
    end else if (s_q.mode[M_ARNG]) begin
      s_d.rd = ph ? L_GRN : L_RED;  // [R3]
    end else if (s_q.mode[M_SRNG]) begin
      s_d.rd = ph ? L_GRN : L_YEL;  // [R3]
    end else if (s_q.mode[M_RDY]) begin
      s_d.rd = L_GRN;
    end else begin
      s_d.rd = L_RED;
    end
    // failure lamp
    if (s_q.fatal) begin
      s_d.fl = L_RED;  // [R5]
    end else if (s_q.mode[M_UNPAR] || s_q.mode[M_PREJ]) begin
      s_d.fl = ph ? L_RED : L_OFF;  // [R4]
    end else begin
      s_d.fl = L_OFF;
    end
    // safe communication lamp
    if (s_q.mode[M_CABLE]) begin
      s_d.sc = L_RED;  // [R8]
    end else if (s_q.fatal || !s_q.mode[M_STRF]) begin
      s_d.sc = L_OFF;  // [R8] [R5]
    end else if (s_q.mode[M_USER]) begin
      s_d.sc = ph ? L_GRN : L_OFF;  // [R7]
    end else begin
      s_d.sc = L_GRN;
    end
    // system diagnosis lamp
    if (s_q.mode[M_ERR]) begin
      s_d.dg = L_RED;  // [R9]
    end else if (s_q.mode[M_WARN]) begin
      s_d.dg = L_YEL;
    end else begin
      s_d.dg = L_OFF;
    end
    s_d.inL = s_q.filt;  // [R10]
    for (int k = 0; k < NOUT; k++) begin
      if (outErr[k]) begin
        s_d.outL[k] = L_RED;  // [R11]
      end else if (s_q.drive[k]) begin
        s_d.outL[k] = L_GRN;
      end else begin
        s_d.outL[k] = L_OFF;
      end
    end
    // apb: read data and error captured in the setup cycle
    if (setup) begin
      s_d.slverr = ~mapped;
      s_d.rdata  = '0;
      case (paddr)
        A_MODE:  s_d.rdata = 32'(s_q.mode);
        A_CFG:   s_d.rdata = 32'({s_q.filtMs, 6'h00, s_q.pair});
        A_CMD:   s_d.rdata = 32'(s_q.cmd);
        A_STAT:  s_d.rdata = 32'({s_q.dreq, s_q.stEn, s_q.fatal,
                                  s_q.drive, s_q.image});
        A_DIAG:  s_d.rdata = 32'(s_q.code);
        default: s_d.rdata = '0;
      endcase
    end
    if (wrAcc) begin
      case (paddr)
        A_MODE: s_d.mode = pwdata[MODE_W-1:0];
        A_CFG: begin
          s_d.pair   = pwdata[C_PAIR +: NPAIR];
          s_d.filtMs = pwdata[C_FILT +: FILT_W];
        end
        A_CMD:   s_d.cmd = pwdata[NOUT-1:0];
        default: s_d.cmd = s_q.cmd;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready        = psel & penable;
  assign prdata        = s_q.rdata;
  assign pslverr       = s_q.slverr & psel & penable;
  assign inImage       = s_q.image;
  assign diagReq       = s_q.dreq;
  assign diagCode      = s_q.code;
  assign safeCommBlock = s_q.fatal;  // [R5]
  assign outDrive      = s_q.drive;
  assign selfTestEn    = s_q.stEn;
  assign linkLamp      = s_q.lk;
  assign readyLamp     = s_q.rd;
  assign failureLamp   = s_q.fl;
  assign safeLamp      = s_q.sc;
  assign systemDiagLight = s_q.dg;
  assign inLamp        = s_q.inL;
  assign outLamp       = s_q.outL;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_fatal_latch;
    s_q.fatal |=> s_q.fatal [*8];
  endproperty
  a_fatal_latch: assert property (p_fatal_latch) else $error("fatal state released"); // [R6]
  property p_fatal_safe;
    s_q.fatal |=> (outDrive == '0) && (inImage == '0) && (failureLamp == L_RED);
  endproperty
  a_fatal_safe: assert property (p_fatal_safe) else $error("fatal state not safe"); // [R5]
  property p_safe_img;
    safe |=> inImage == '0;
  endproperty
  a_safe_img: assert property (p_safe_img) else $error("image not zero in safe state"); // [R12]
  property p_safe_out;
    safe |=> outDrive == '0;
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("output on in safe state"); // [R13]
  property p_out_err;
    ##1 (outDrive & $past(outErr)) == '0;
  endproperty
  a_out_err: assert property (p_out_err) else $error("faulty output still driven"); // [R15]
  property p_pair;
    s_q.pair[0] && s_q.o2[0] |=> !outDrive[1];
  endproperty
  a_pair: assert property (p_pair) else $error("partner channel left on"); // [R16]
  property p_in_fault;
    ##1 (inImage & $past(s_q.f2)) == '0;
  endproperty
  a_in_fault: assert property (p_in_fault) else $error("faulty input reported set"); // [R14]
  property p_diag;
    |errNew |=> diagReq && (diagCode == $past(errVec));
  endproperty
  a_diag: assert property (p_diag) else $error("new error without diagnosis"); // [R18]
  property p_selftest;
    |errVec |=> !selfTestEn;
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test running in error"); // [R19]
  property p_diag_red;
    s_q.mode[M_ERR] |=> systemDiagLight == L_RED;
  endproperty
  a_diag_red: assert property (p_diag_red) else $error("diagnosis lamp not red"); // [R9]
  property p_hold;
    s_q.hold[0] && !taken |=> !inImage[0];
  endproperty
  a_hold: assert property (p_hold) else $error("safety request not held"); // [R21]
  property p_in_lamp;
    ##1 inLamp == $past(s_q.filt);
  endproperty
  a_in_lamp: assert property (p_in_lamp) else $error("input lamp mismatch"); // [R10]

  c_fatal: cover property (s_q.x2[0] ##1 s_q.fatal);
  c_diag:  cover property (diagReq ##[1:20] !diagReq);
  c_pair:  cover property (s_q.pair[0] && s_q.o2[1] && s_q.cmd[0]);
endmodule : ssi_top
`default_nettype wire

/* File: verification/ssi_ctrl_model.sv */
/*
  ssi_ctrl_model: far-side safety controller; takes the input image and
  acknowledges diagnostics with pulses three cycles wide.
  Assumes clk and rst of the block; the bench commands each take.
*/
`timescale 1ns/100ps
`default_nettype none
module ssi_ctrl_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench control
  input  wire logic take,
  input  wire logic ackEn,
  // link side
  input  wire logic diagReq,
  output logic      imageTaken,
  output logic      diagAck
);
  logic [2:0] tkCnt_q;
  logic [2:0] akCnt_q;

  // high 3 cycles, then low at least 4, so repeated pulses stay spaced
  always_ff @(posedge clk) begin
    if (rst) begin
      tkCnt_q <= 3'h0;
      akCnt_q <= 3'h0;
    end else begin
      if (take && tkCnt_q == 3'h0) tkCnt_q <= 3'h7;
      else if (tkCnt_q != 3'h0) tkCnt_q <= tkCnt_q - 3'h1;
      if (ackEn && diagReq && akCnt_q == 3'h0) akCnt_q <= 3'h7;
      else if (akCnt_q != 3'h0) akCnt_q <= akCnt_q - 3'h1;
    end
  end
  assign imageTaken = (tkCnt_q > 3'h4);
  assign diagAck    = (akCnt_q > 3'h4);
endmodule : ssi_ctrl_model
`default_nettype wire

/* File: verification/ssi_top_tb_top.sv */
/*
  ssi_top_tb_top: self-checking bench for ssi_top over APB and pins.
  Assumes short counts: 10 cycles a millisecond, blink half period 4.
*/
`timescale 1ns/100ps
`default_nettype none
module ssi_top_tb_top;
  import ssi_pkg::*;
  typedef struct packed {
    logic [15:0] m;
    logic [2:0]  k;
    ssi_lamp_e   a;
    ssi_lamp_e   b;
  } ssi_row_s;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, fatalErr = 1'b0, imageTaken, diagAck;
  logic [NIN-1:0] inRaw = '0, inFault = '0, inImage, inLamp;
  logic [NOUT-1:0] outFault = '0, outDrive, c;
  logic [NCLK-1:0] clkOutFault = '0;
  logic [DIAG_W-1:0] diagCode;
  logic diagReq, safeCommBlock, selfTestEn, take = 1'b0, ackEn = 1'b0;
  ssi_lamp_e linkLamp, readyLamp, failureLamp, safeLamp, systemDiagLight;
  ssi_lamp_e [NOUT-1:0] outLamp;
  logic [7:0] lf = 8'h42;
  int errorCnt = 0, nCompared = 0, n;
  ssi_row_s tbl [21] = '{
    '{16'h0001, 3'd0, L_GRN, L_GRN}, '{16'h0003, 3'd0, L_GRN, L_OFF},
    '{16'h0000, 3'd0, L_OFF, L_OFF}, '{16'h0004, 3'd0, L_YEL, L_RED},
    '{16'h0060, 3'd1, L_GRN, L_GRN}, '{16'h0048, 3'd1, L_YEL, L_YEL},
    '{16'h0050, 3'd1, L_YEL, L_OFF}, '{16'h0040, 3'd1, L_RED, L_RED},
    '{16'h0140, 3'd1, L_GRN, L_RED}, '{16'h00c0, 3'd1, L_GRN, L_YEL},
    '{16'h0000, 3'd1, L_OFF, L_OFF}, '{16'h0200, 3'd2, L_RED, L_OFF},
    '{16'h0400, 3'd2, L_RED, L_OFF}, '{16'h0000, 3'd2, L_OFF, L_OFF},
    '{16'h0800, 3'd3, L_GRN, L_GRN}, '{16'h1800, 3'd3, L_GRN, L_OFF},
    '{16'h0000, 3'd3, L_OFF, L_OFF}, '{16'h2000, 3'd3, L_RED, L_RED},
    '{16'h4000, 3'd4, L_YEL, L_YEL}, '{16'h8000, 3'd4, L_RED, L_RED},
    '{16'h0000, 3'd4, L_OFF, L_OFF}};

  always #5 clk = ~clk;

  ssi_top #(.MS_CYC(10), .TFW_CYC(40), .BLINK_CYC(4)) ssi_top_inst (
    .clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .inRaw, .inFault, .outFault, .clkOutFault, .fatalErr,
    .imageTaken, .diagAck, .inImage, .diagReq, .diagCode, .safeCommBlock,
    .outDrive, .selfTestEn, .linkLamp, .readyLamp, .failureLamp, .safeLamp,
    .systemDiagLight, .inLamp, .outLamp);

  ssi_ctrl_model ssi_ctrl_model_inst (
    .clk, .rst, .take, .ackEn, .diagReq, .imageTaken, .diagAck);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic ssi_lamp_e pick(input logic [2:0] k);
    case (k)
      3'd0: return linkLamp;
      3'd1: return readyLamp;
      3'd2: return failureLamp;
      3'd3: return safeLamp;
      default: return systemDiagLight;
    endcase
  endfunction : pick

  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : printVerdict

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    nCompared++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      errorCnt++;
    end
  endtask : chk

  // steady when a equals b, else both colours must show within 24 cycles
  task automatic chk_lamp(input string nm, input logic [2:0] k, input ssi_lamp_e a,
                          input ssi_lamp_e b);
    bit sa = 0, sb = 0, bad = 0;
    repeat (24) begin
      @(posedge clk);
      if (pick(k) === a) sa = 1;
      else if (pick(k) === b) sb = 1;
      else bad = 1;
    end
    nCompared++;
    if (bad || !sa || (a != b && !sb)) begin
      $display("MISMATCH %s expected %s/%s seen %s", nm, a.name(), b.name(), pick(k).name());
      errorCnt++;
    end
  endtask : chk_lamp

  task automatic apb(input logic [AW-1:0] a, input logic w, input logic [31:0] d);
    int t = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      $display("MISMATCH pready expected 1 seen %b", pready);
      errorCnt++;
      printVerdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never reassigns psel in this step
    @(posedge clk);
  endtask : apb

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic pulse_take();
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    cyc(12);
  endtask : pulse_take

  initial begin
    cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    chk("outDrive", 0, outDrive);
    chk("failureLamp", L_OFF, failureLamp);
    apb(A_MODE, 1'b1, 32'h8001);
    apb(A_MODE, 1'b0, 0);
    chk("MODE", 32'h8001, r);
    apb(A_MODE, 1'b1, 0);
    apb(A_CFG, 1'b1, 32'h0103);
    apb(A_CFG, 1'b0, 0);
    chk("CFG", 32'h0103, r);
    apb(A_CMD, 1'b1, 32'h5);
    apb(A_STAT, 1'b1, 32'hffffffff);
    chk("pslverr STAT", 0, e);
    cyc(6);
    apb(A_STAT, 1'b0, 0);
    chk("STAT", 32'h2500, r);
    apb(8'h20, 1'b1, 32'h1);
    chk("pslverr wr", 1, e);
    apb(8'h20, 1'b0, 0);
    chk("unmapped", 0, r);
    chk("pslverr rd", 1, e);
    $display("test registers done");
    apb(A_CFG, 1'b1, 32'h0200);
    inRaw <= 8'h01;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (inImage[0] !== 1'b1 && n < 200);
    chk("tIn window", 1, n >= 60 && n <= 66);
    inRaw <= 8'h00;
    cyc(100);
    chk("image low", 8'h00, inImage);
    inRaw <= 8'h01;
    cyc(100);
    chk("inLamp back", 8'h01, inLamp);
    chk("image held", 8'h00, inImage);
    pulse_take();
    chk("image released", 8'h01, inImage);
    $display("test timing done");
    apb(A_CFG, 1'b1, 32'h0100);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      inRaw <= lf;
      lf = lfsr(lf);
      c = lf[3:0];
      apb(A_CMD, 1'b1, c);
      cyc(60);
      pulse_take();
      chk("inImage", inRaw, inImage);
      chk("inLamp", inRaw, inLamp);
      chk("outDrive", c, outDrive);
      for (int j = 0; j < NOUT; j++) chk("outLamp", c[j] ? L_GRN : L_OFF, outLamp[j]);
      apb(A_STAT, 1'b0, 0);
      chk("STAT low", {c, inRaw}, r[11:0]);
    end
    $display("test random done");
    inRaw <= 8'hff;
    apb(A_CMD, 1'b1, 32'hf);
    apb(A_CFG, 1'b1, 32'h0101);
    cyc(60);
    pulse_take();
    chk("selfTestEn", 1, selfTestEn);
    inFault <= 8'h08;
    cyc(20);
    chk("inImage", 8'hf7, inImage);
    chk("selfTestEn", 0, selfTestEn);
    chk("diagReq", 1, diagReq);
    chk("diagCode", 17'h01000, diagCode);
    apb(A_DIAG, 1'b0, 0);
    chk("DIAG", 32'h01000, r);
    ackEn <= 1'b1;
    cyc(20);
    chk("diagReq", 0, diagReq);
    inFault <= 8'h00;
    outFault <= 4'b0101;
    cyc(8);
    chk("outDrive", 4'b1000, outDrive);
    chk("outLamp0", L_RED, outLamp[0]);
    chk("outLamp3", L_GRN, outLamp[3]);
    outFault <= 4'h0;
    clkOutFault <= 2'b01;
    cyc(8);
    chk("inImage", 0, inImage);
    clkOutFault <= 2'b00;
    $display("test faults done");
    foreach (tbl[i]) begin
      apb(A_MODE, 1'b1, tbl[i].m);
      cyc(8);
      chk_lamp("lamp", tbl[i].k, tbl[i].a, tbl[i].b);
    end
    $display("test lamps done");
    fatalErr <= 1'b1;
    cyc(4);
    fatalErr <= 1'b0;
    cyc(6);
    chk("safeCommBlock", 1, safeCommBlock);
    chk("outDrive", 0, outDrive);
    chk("inImage", 0, inImage);
    chk_lamp("failLamp", 3'd2, L_RED, L_RED);
    apb(A_MODE, 1'b1, 0);
    apb(A_CMD, 1'b1, 32'hf);
    cyc(6);
    chk("fatal kept", 1, safeCommBlock);
    chk("outDrive", 0, outDrive);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    chk("safeCommBlock", 0, safeCommBlock);
    apb(A_CMD, 1'b0, 0);
    chk("CMD reset", 0, r);
    $display("test fatal done");
    printVerdict();
  end
endmodule : ssi_top_tb_top
`default_nettype wire
